// file: core/i2c_fram_pkg.sv
// Shared constants and types for the two-wire memory slave and its master
package i2c_fram_pkg;
  // ****************************************
  // Memory and slave address
  // ****************************************
  localparam logic [3:0] DEV_TYPE = 4'hA;
  localparam int ADDR_W = 9;
  localparam int BYTE_BITS = 8;
  localparam logic [4:0] SYNC_RST = 5'h03;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCL_QUARTER_NS = 2500;
  localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ****************************************
  // Controller registers
  // ****************************************
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CMD_OP_LSB = 8;
  localparam int CMD_ACK_BIT = 10;
  localparam logic [10:0] CMD_RST = 11'h000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {OP_WRITE = 2'b00, OP_READ = 2'b01, OP_START = 2'b10, OP_STOP = 2'b11} op_t;
  // ****************************************
  // State machines
  // ****************************************
  typedef enum logic [2:0] {
    DS_IDLE = 3'b000, DS_SADDR = 3'b001, DS_SACK = 3'b011, DS_RX = 3'b010,
    DS_RXACK = 3'b110, DS_TX = 3'b111, DS_TXACK = 3'b101, DS_SKIP = 3'b100
  } dev_state_t;
  typedef enum logic [1:0] {HS_IDLE = 2'b00, HS_START = 2'b01, HS_BIT = 2'b11, HS_STOP = 2'b10} host_state_t;
endpackage

// file: core/i2c_fram_if.sv
// Two-wire bus carrier joining the memory slave and the master
`timescale 1ns/1ps
interface i2c_fram_if;
  logic scl_o;
  logic scl_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl;
  logic sda;
  // Open-drain wires with pull-up
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = (sda_host_oe ? sda_host_o : 1'b1) & (sda_dev_oe ? sda_dev_o : 1'b1);
  modport host (output scl_o, output scl_oe, output sda_host_o, output sda_host_oe, input scl, input sda);
  modport dev (output sda_dev_o, output sda_dev_oe, input scl, input sda);
endinterface

// file: core/i2c_fram_dev.sv
// Two-wire 512 x 8 memory slave
// Notes on behaviour
// - SDA rise, SCL high: stop, abort.
// - SDA fall, SCL high: start, expect address.
// - Receiver acks ninth clock; high aborts.
// - Master leaves last read byte unacknowledged.
// - Address bits 7-4 must be 1010b.
// - Address bits 3-2 match select pins.
// - Address bit 1 is address bit 8.
// - Address bit 0: one read, zero write.
// - Write: next byte loads low address bits.
// - Read uses page bit plus held bits.
// - Increment before ack, wrap 1FFh to 000h.
// - No page boundary, no byte limit.
// - Read: ack sends next, nack releases.
// - Write: receive eight, ack; MSB first.
// - Commit on eighth bit; abort leaves memory.
// - Protected: no ack, no write, no increment.
// - Protect pin low enables all writes.
// - Read data starts on next clock.
// - Read ends by nack or start/stop.
// - Random read: write address, repeated start.
// - Always ready; polling always acknowledged.
// - Master changes SDA only while SCL low.
// - Sample on SCL rise, drive after fall.
`timescale 1ns/1ps
module i2c_fram_dev #(
  parameter int ADDR_W = i2c_fram_pkg::ADDR_W
)
(
  input wire logic aclk,
  input wire logic aresetn,
  i2c_fram_if.dev bus,
  input wire logic [1:0] device_select_pins,
  input wire logic write_protect
);
  localparam int DEPTH = 2 ** ADDR_W;
  if (ADDR_W != i2c_fram_pkg::BYTE_BITS + 1)
  begin : g_chk
    $error("ADDR_W must be one page bit above a byte");
  end
  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Bits: 0 sda, 1 scl, 3:2 select, 4 protect
  logic [4:0] s1_q, s2_q, s3_q, filt_q, prev_q;
  wire [4:0] pins = {write_protect, device_select_pins, bus.scl, bus.sda};
  // A level counts only once two stages agree
  wire [4:0] filt_d = (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_q <= i2c_fram_pkg::SYNC_RST;
      s2_q <= i2c_fram_pkg::SYNC_RST;
      s3_q <= i2c_fram_pkg::SYNC_RST;
      filt_q <= i2c_fram_pkg::SYNC_RST;
      prev_q <= i2c_fram_pkg::SYNC_RST;
    end
    else
    begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
      prev_q <= filt_q;
    end
  end
  wire sda_f = filt_q[0];
  wire scl_f = filt_q[1];
  wire [1:0] sel_f = filt_q[3:2];
  wire wp_f = filt_q[4];
  wire scl_rise = scl_f & ~prev_q[1];
  wire scl_fall = ~scl_f & prev_q[1];
  wire start_det = scl_f & prev_q[1] & ~sda_f & prev_q[0];
  wire stop_det = scl_f & prev_q[1] & sda_f & ~prev_q[0];
  // ****************************************
  // Array and decode
  // ****************************************
  logic [7:0] mem [0:DEPTH-1];
  i2c_fram_pkg::dev_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic page_q, page_d, rd_q, rd_d, aphase_q, aphase_d, drv_q, drv_d, mack_q, mack_d;
  wire [7:0] rx_byte = {sh_q[6:0], sda_f};
  wire last_bit = cnt_q == 4'd7;
  wire byte_end = cnt_q == 4'd8;
  wire sel_ok = (sh_q[7:4] == i2c_fram_pkg::DEV_TYPE) && (sh_q[3:2] == sel_f);
  wire [ADDR_W-1:0] cur_addr = {page_q, addr_q[7:0]};
  wire [ADDR_W-1:0] rd_addr = (st_q == i2c_fram_pkg::DS_SACK) ? cur_addr : addr_q;
  wire [7:0] rd_byte = mem[rd_addr];
  wire rx_ok = aphase_q || !wp_f;
  // Written at the eighth rise only, so an earlier start or stop leaves the array alone
  wire commit = scl_rise && !start_det && !stop_det && st_q == i2c_fram_pkg::DS_RX
    && last_bit && !aphase_q && !wp_f;
  always_ff @(posedge aclk)
  begin
    if (commit)
    begin
      mem[addr_q] <= rx_byte;
    end
  end
  // ****************************************
  // Protocol engine
  // ****************************************
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    addr_d = addr_q;
    page_d = page_q;
    rd_d = rd_q;
    aphase_d = aphase_q;
    drv_d = drv_q;
    mack_d = mack_q;
    if (stop_det)
    begin
      st_d = i2c_fram_pkg::DS_IDLE;
      drv_d = 1'b0;
    end
    else if (start_det)
    begin
      st_d = i2c_fram_pkg::DS_SADDR;
      cnt_d = 4'd0;
      drv_d = 1'b0;
    end
    else if (scl_rise)
    begin
      case (st_q)
        i2c_fram_pkg::DS_SADDR, i2c_fram_pkg::DS_RX:
        begin
          sh_d = rx_byte;
          cnt_d = cnt_q + 4'd1;
          if (st_q == i2c_fram_pkg::DS_RX && last_bit)
          begin
            if (aphase_q)
              addr_d = {page_q, rx_byte};
            else if (!wp_f)
              addr_d = addr_q + 9'd1;
          end
        end
        i2c_fram_pkg::DS_TX:
        begin
          cnt_d = cnt_q + 4'd1;
          if (last_bit)
            addr_d = addr_q + 9'd1;
        end
        i2c_fram_pkg::DS_TXACK: mack_d = ~sda_f;
        default: ;
      endcase
    end
    else if (scl_fall)
    begin
      case (st_q)
        i2c_fram_pkg::DS_SADDR:
        begin
          if (byte_end && sel_ok)
          begin
            st_d = i2c_fram_pkg::DS_SACK;
            drv_d = 1'b1;
            page_d = sh_q[1];
            rd_d = sh_q[0];
          end
          else if (byte_end)
            st_d = i2c_fram_pkg::DS_SKIP;
        end
        i2c_fram_pkg::DS_SACK:
        begin
          cnt_d = 4'd0;
          if (rd_q)
          begin
            // First bit goes out on the clock right after the ack
            st_d = i2c_fram_pkg::DS_TX;
            addr_d = cur_addr;
            drv_d = ~rd_byte[7];
            sh_d = {rd_byte[6:0], 1'b1};
          end
          else
          begin
            st_d = i2c_fram_pkg::DS_RX;
            aphase_d = 1'b1;
            drv_d = 1'b0;
          end
        end
        i2c_fram_pkg::DS_RX:
        begin
          if (byte_end && rx_ok)
          begin
            st_d = i2c_fram_pkg::DS_RXACK;
            drv_d = 1'b1;
          end
          else if (byte_end)
            st_d = i2c_fram_pkg::DS_SKIP;
        end
        i2c_fram_pkg::DS_RXACK:
        begin
          st_d = i2c_fram_pkg::DS_RX;
          cnt_d = 4'd0;
          aphase_d = 1'b0;
          drv_d = 1'b0;
        end
        i2c_fram_pkg::DS_TX:
        begin
          if (byte_end)
          begin
            st_d = i2c_fram_pkg::DS_TXACK;
            drv_d = 1'b0;
          end
          else
          begin
            drv_d = ~sh_q[7];
            sh_d = {sh_q[6:0], 1'b1};
          end
        end
        i2c_fram_pkg::DS_TXACK:
        begin
          if (mack_q)
          begin
            st_d = i2c_fram_pkg::DS_TX;
            cnt_d = 4'd0;
            drv_d = ~rd_byte[7];
            sh_d = {rd_byte[6:0], 1'b1};
          end
          else
            st_d = i2c_fram_pkg::DS_SKIP;
        end
        default: ;
      endcase
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= i2c_fram_pkg::DS_IDLE;
      cnt_q <= 4'd0;
      sh_q <= 8'h00;
      addr_q <= 9'h000;
      page_q <= 1'b0;
      rd_q <= 1'b0;
      aphase_q <= 1'b0;
      drv_q <= 1'b0;
      mack_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      addr_q <= addr_d;
      page_q <= page_d;
      rd_q <= rd_d;
      aphase_q <= aphase_d;
      drv_q <= drv_d;
      mack_q <= mack_d;
    end
  end
  // Open drain: only ever pulls low
  assign bus.sda_dev_o = 1'b0;
  assign bus.sda_dev_oe = drv_q;
endmodule

// file: core/i2c_fram_host.sv
// Two-wire bus master with an AXI4-Lite command port
`timescale 1ns/1ps
module i2c_fram_host #(
  parameter int QCYC = i2c_fram_pkg::SCL_QUARTER_CYC
)
(
  input wire logic aclk,
  input wire logic aresetn,
  i2c_fram_if.host bus,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  if (QCYC < 1 || QCYC > 256)
  begin : g_chk
    $error("QCYC must be 1 to 256");
  end
  // ****************************************
  // Register slave
  // ****************************************
  logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [10:0] cmd_q;
  logic [7:0] rxb_q;
  logic nack_q;
  i2c_fram_pkg::host_state_t hs_q;
  wire busy = hs_q != i2c_fram_pkg::HS_IDLE;
  wire wr_fire = aw_have_q && w_have_q && !bvalid_q;
  wire cmd_hit = aw_addr_q == i2c_fram_pkg::REG_CMD;
  // Commands during a transfer are dropped; software polls busy first
  wire cmd_ok = wr_fire && cmd_hit && (&w_strb_q[1:0]) && !busy;
  wire ar_fire = arvalid && !rvalid_q;
  wire ar_cmd = araddr == i2c_fram_pkg::REG_CMD;
  wire ar_stat = araddr == i2c_fram_pkg::REG_STATUS;
  wire [31:0] stat_word = {16'h0000, rxb_q, 6'h00, nack_q, busy};
  wire [31:0] rd_word = ar_cmd ? {21'h00000, cmd_q} : (ar_stat ? stat_word : 32'h00000000);
  assign awready = !aw_have_q && !bvalid_q;
  assign wready = !w_have_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bresp_q <= i2c_fram_pkg::RESP_OKAY;
      rresp_q <= i2c_fram_pkg::RESP_OKAY;
      rdata_q <= 32'h00000000;
      cmd_q <= i2c_fram_pkg::CMD_RST;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_have_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_fire)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= cmd_hit ? i2c_fram_pkg::RESP_OKAY : i2c_fram_pkg::RESP_SLVERR;
      end
      else if (bready)
        bvalid_q <= 1'b0;
      if (cmd_ok)
        cmd_q <= w_data_q[10:0];
      if (ar_fire)
      begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= (ar_cmd || ar_stat) ? i2c_fram_pkg::RESP_OKAY : i2c_fram_pkg::RESP_SLVERR;
      end
      else if (rready)
        rvalid_q <= 1'b0;
    end
  end
  // ****************************************
  // Bus engine
  // ****************************************
  logic s1_q, s2_q, s3_q, sda_f_q;
  logic [7:0] div_q;
  logic [1:0] qtr_q;
  logic [3:0] bitn_q;
  logic [8:0] tx_q, rsh_q;
  logic scl_oe_q, sda_oe_q;
  wire i2c_fram_pkg::op_t op = i2c_fram_pkg::op_t'(w_data_q[i2c_fram_pkg::CMD_OP_LSB+1:i2c_fram_pkg::CMD_OP_LSB]);
  // Ack bit one on the last read byte ends the read cleanly
  wire ack_bit = w_data_q[i2c_fram_pkg::CMD_ACK_BIT];
  wire tick = busy && div_q == 8'h00;
  wire done = tick && qtr_q == 2'd3 && (hs_q != i2c_fram_pkg::HS_BIT || bitn_q == 4'd8);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      sda_f_q <= 1'b1;
    end
    else
    begin
      s1_q <= bus.sda;
      s2_q <= s1_q;
      s3_q <= s2_q;
      sda_f_q <= (s2_q == s3_q) ? s3_q : sda_f_q;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hs_q <= i2c_fram_pkg::HS_IDLE;
      div_q <= 8'h00;
      qtr_q <= 2'd0;
      bitn_q <= 4'd0;
      tx_q <= 9'h1FF;
      rsh_q <= 9'h1FF;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      rxb_q <= 8'h00;
      nack_q <= 1'b0;
    end
    else if (cmd_ok)
    begin
      hs_q <= (op == i2c_fram_pkg::OP_START) ? i2c_fram_pkg::HS_START :
        (op == i2c_fram_pkg::OP_STOP) ? i2c_fram_pkg::HS_STOP : i2c_fram_pkg::HS_BIT;
      div_q <= 8'(QCYC - 1);
      qtr_q <= 2'd0;
      bitn_q <= 4'd0;
      // Ninth bit released on a write so the slave can ack
      tx_q <= (op == i2c_fram_pkg::OP_READ) ? {8'hFF, ack_bit} : {w_data_q[7:0], 1'b1};
    end
    else if (tick)
    begin
      div_q <= 8'(QCYC - 1);
      qtr_q <= qtr_q + 2'd1;
      case (hs_q)
        i2c_fram_pkg::HS_START:
        begin
          // Works as a repeated start after an address ack too
          if (qtr_q == 2'd0) sda_oe_q <= 1'b0;
          if (qtr_q == 2'd1) scl_oe_q <= 1'b0;
          if (qtr_q == 2'd2) sda_oe_q <= 1'b1;
          if (qtr_q == 2'd3) scl_oe_q <= 1'b1;
        end
        i2c_fram_pkg::HS_STOP:
        begin
          if (qtr_q == 2'd0) sda_oe_q <= 1'b1;
          if (qtr_q == 2'd1) scl_oe_q <= 1'b0;
          if (qtr_q == 2'd2) sda_oe_q <= 1'b0;
        end
        default:
        begin
          if (qtr_q == 2'd0) sda_oe_q <= ~tx_q[8];
          if (qtr_q == 2'd1) scl_oe_q <= 1'b0;
          if (qtr_q == 2'd2) rsh_q <= {rsh_q[7:0], sda_f_q};
          if (qtr_q == 2'd3)
          begin
            scl_oe_q <= 1'b1;
            tx_q <= {tx_q[7:0], 1'b1};
            bitn_q <= bitn_q + 4'd1;
          end
        end
      endcase
      if (done)
      begin
        hs_q <= i2c_fram_pkg::HS_IDLE;
        if (hs_q == i2c_fram_pkg::HS_BIT)
        begin
          rxb_q <= rsh_q[8:1];
          nack_q <= rsh_q[0];
        end
      end
    end
    else if (busy)
      div_q <= div_q - 8'h01;
  end
  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = scl_oe_q;
  assign bus.sda_host_o = 1'b0;
  assign bus.sda_host_oe = sda_oe_q;
endmodule

// file: testbench/i2c_fram_props.sv
// Bus-level checks for the two-wire memory link
`timescale 1ns/1ps
module i2c_fram_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic [1:0] device_select_pins,
  input wire logic write_protect
);
  // ****************************************
  // Bit and byte tracking on the raw wires
  // ****************************************
  logic scl_q, sda_q, rd_q, mm_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [1:0] nb_q;
  wire rise = scl && !scl_q;
  wire cond = scl && scl_q && (sda != sda_q);
  wire ninth = rise && cnt_q == 4'h8;
  wire match = sh_q[7:4] == i2c_fram_pkg::DEV_TYPE && sh_q[3:2] == device_select_pins;
  wire wr_ack = nb_q != 2'h0 && !rd_q && !mm_q && !(nb_q == 2'h2 && write_protect);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
      cnt_q <= 4'h0;
      nb_q <= 2'h0;
      mm_q <= 1'h0;
      rd_q <= 1'h0;
      sh_q <= 8'h00;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      // Start or stop restarts framing; byte count saturates at data
      if (cond)
      begin
        cnt_q <= 4'h0;
        nb_q <= 2'h0;
        mm_q <= 1'h0;
      end
      else if (ninth)
      begin
        cnt_q <= 4'h0;
        nb_q <= (nb_q == 2'h2) ? nb_q : nb_q + 2'h1;
        if (nb_q == 2'h0)
        begin
          rd_q <= sh_q[0];
          mm_q <= !match;
        end
      end
      else if (rise)
      begin
        cnt_q <= cnt_q + 4'h1;
        sh_q <= {sh_q[6:0], sda};
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  odrain_a: assert property (sda_dev_oe |-> sda_dev_o == 1'h0)
    else $error("device drives data line high");
  dev_edge_a: assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("device changed data while clock high");
  start_free_a: assert property (scl && $past(scl) && $fell(sda) |-> ##6 !sda_dev_oe [*8])
    else $error("device drives after start");
  stop_free_a: assert property (scl && $past(scl) && $rose(sda) |-> !sda_dev_oe [*8])
    else $error("device drives after stop");
  addr_ack_a: assert property (ninth && nb_q == 2'h0 && match |-> !sda)
    else $error("matching address not acknowledged");
  addr_nack_a: assert property (ninth && nb_q == 2'h0 && !match |-> sda)
    else $error("foreign address acknowledged");
  mute_dev_a: assert property (mm_q |-> !sda_dev_oe)
    else $error("unselected device drives data");
  data_ack_a: assert property (ninth && wr_ack |-> !sda)
    else $error("written byte not acknowledged");
  wp_nack_a: assert property (ninth && nb_q == 2'h2 && !rd_q && write_protect |-> sda)
    else $error("protected byte acknowledged");
  rd_end_a: assert property (ninth && nb_q != 2'h0 && rd_q && sda |-> ##10 !sda_dev_oe [*8])
    else $error("device kept driving after read nack");
endmodule

// file: testbench/tb.sv
// Self-checking bench: AXI master orders the two-wire master to work the memory slave
`timescale 1ns/1ps
module tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, write_protect;
  logic awready, wready, bvalid, arready, rvalid;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, st;
  logic [1:0] bresp, rresp, rsp, device_select_pins;
  int errors, checks;
  int cyc = 0;

  i2c_fram_if bus();
  i2c_fram_dev i_i2c_fram_dev (.aclk(aclk), .aresetn(aresetn), .bus(bus),
    .device_select_pins(device_select_pins), .write_protect(write_protect));
  // Short quarter keeps the run brief and the device filter comfortable
  i2c_fram_host #(.QCYC(4)) i_i2c_fram_host (.aclk(aclk), .aresetn(aresetn), .bus(bus),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  i2c_fram_props i_i2c_fram_props (.aclk(aclk), .aresetn(aresetn), .scl(bus.scl), .sda(bus.sda),
    .sda_dev_o(bus.sda_dev_o), .sda_dev_oe(bus.sda_dev_oe),
    .device_select_pins(device_select_pins), .write_protect(write_protect));

  initial
  begin
    aclk = 1'h0;
    forever #25 aclk = ~aclk;
  end

  // ****************************************
  // Bus and command tasks
  // ****************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw, bd;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    bd = 1'h0;
    while (!bd)
    begin
      // Mid-cycle look equals what the next rising edge samples
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      bd = bvalid;
      rsp = bresp;
      @(posedge aclk);
      if (ta)
        awvalid <= 1'h0;
      if (tw)
        wvalid <= 1'h0;
    end
    bready <= 1'h0;
    // Idle edge so a following call never assigns a strobe twice in one step
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    logic ta, rd;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    rd = 1'h0;
    while (!rd)
    begin
      @(negedge aclk);
      ta = arvalid && arready;
      rd = rvalid;
      d = rdata;
      rsp = rresp;
      @(posedge aclk);
      if (ta)
        arvalid <= 1'h0;
    end
    rready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic op(input logic [1:0] o, input logic [7:0] b, input logic ack);
    axi_wr(i2c_fram_pkg::REG_CMD, {21'h0, ack, o, b});
    st = 32'h1;
    while (st[0] !== 1'h0)
      axi_rd(i2c_fram_pkg::REG_STATUS, st);
  endtask

  task automatic sta();
    op(i2c_fram_pkg::OP_START, 8'h00, 1'h0);
  endtask

  task automatic sto();
    op(i2c_fram_pkg::OP_STOP, 8'h00, 1'h0);
  endtask

  task automatic wrb(input logic [7:0] b, input logic nack);
    op(i2c_fram_pkg::OP_WRITE, b, 1'h0);
    chk("slave ack", 32'(nack), 32'(st[1]));
  endtask

  task automatic rdb(input logic nack, input logic [7:0] e);
    op(i2c_fram_pkg::OP_READ, 8'h00, nack);
    chk("read byte", 32'(e), 32'(st[15:8]));
  endtask

  function automatic logic [7:0] sa(input logic pg, input logic rd);
    return {i2c_fram_pkg::DEV_TYPE, device_select_pins, pg, rd};
  endfunction

  task automatic rnd(input logic pg, input logic [7:0] a);
    sta();
    wrb(sa(pg, 1'h0), 1'h0);
    wrb(a, 1'h0);
    sta();
    wrb(sa(pg, 1'h1), 1'h0);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      errors++;
      finish_test();
    end
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    errors = 0;
    checks = 0;
    aresetn = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready, write_protect} = 6'h00;
    {awaddr, araddr, wdata} = 40'h0;
    wstrb = 4'hF;
    device_select_pins = 2'h2;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    axi_rd(i2c_fram_pkg::REG_STATUS, st);
    chk("status reset", 32'h0, st);
    axi_rd(i2c_fram_pkg::REG_CMD, st);
    chk("cmd reset", 32'h0, st);
    axi_rd(4'h8, st);
    chk("read resp", 32'(i2c_fram_pkg::RESP_SLVERR), 32'(rsp));
    axi_wr(4'hC, 32'h0);
    chk("write resp", 32'(i2c_fram_pkg::RESP_SLVERR), 32'(rsp));
    $display("test registers done");
    sta();
    wrb(sa(1'h1, 1'h0), 1'h0);
    wrb(8'hFE, 1'h0);
    wrb(8'h11, 1'h0);
    wrb(8'h22, 1'h0);
    wrb(8'h33, 1'h0);
    sto();
    rnd(1'h1, 8'hFE);
    rdb(1'h0, 8'h11);
    rdb(1'h0, 8'h22);
    rdb(1'h1, 8'h33);
    sto();
    $display("test wrap write and read done");
    sta();
    wrb(sa(1'h0, 1'h0), 1'h0);
    wrb(8'h05, 1'h0);
    wrb(8'h5A, 1'h0);
    wrb(8'h6B, 1'h0);
    sto();
    rnd(1'h0, 8'h05);
    rdb(1'h1, 8'h5A);
    sto();
    sta();
    wrb(sa(1'h0, 1'h1), 1'h0);
    rdb(1'h1, 8'h6B);
    sto();
    $display("test current address done");
    write_protect <= 1'h1;
    sta();
    wrb(sa(1'h0, 1'h0), 1'h0);
    wrb(8'h06, 1'h0);
    wrb(8'h99, 1'h1);
    sto();
    write_protect <= 1'h0;
    sta();
    wrb(sa(1'h0, 1'h1), 1'h0);
    rdb(1'h1, 8'h6B);
    sto();
    $display("test write protect done");
    sta();
    wrb({i2c_fram_pkg::DEV_TYPE, ~device_select_pins, 2'h0}, 1'h1);
    sto();
    sta();
    wrb({4'h9, device_select_pins, 2'h0}, 1'h1);
    sto();
    $display("test foreign address done");
    finish_test();
  end
endmodule
